// [common/vio_link_pkg.sv]
`default_nettype none
package vio_link_pkg;

  // width of the virtual output and virtual input words
  localparam int unsigned WORD_W = 32;

  // bit used in mapping examples: output bit five lands on input bit five
  localparam int unsigned VIRTUAL_OUTPUT_BIT_FIVE = 5;
  localparam int unsigned VIRTUAL_INPUT_BIT_FIVE = 5;

  // most link modules that one base unit may carry
  localparam int unsigned MAX_LINKS_PER_UNIT = 4;

  // clock and longest transfer time
  localparam longint unsigned CLK_HZ = 40_000_000;
  localparam longint unsigned MAX_TRANSFER_MS = 35;
  // longest time rounds down to whole cycles
  localparam longint unsigned MAX_TRANSFER_CYCLES = (MAX_TRANSFER_MS * CLK_HZ) / 1000;

  // serial frame: start bit, 32 data bits, even parity bit
  localparam int unsigned FRAME_BITS = WORD_W + 2;

  // value of the input word after reset or on lost link
  localparam logic [31:0] INPUT_RESET = 32'h0000_0000;

  // transmitter states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GAP   = 3'b100
  } tx_state_e;

  // receiver states
  typedef enum logic [1:0] {
    RX_HUNT  = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_e;

endpackage
`default_nettype wire

// [common/vio_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// point-to-point cable between two link modules; each end drives its own
// transmit line, the crossover wiring makes one end's tx the other's rx
interface vio_link_if;
  logic a_to_b;
  logic b_to_a;
  modport end_a (output a_to_b, input b_to_a);
  modport end_b (output b_to_a, input a_to_b);
endinterface
`default_nettype wire

// [hw/vio_link_end_a.sv]
`timescale 1ns/100ps
`default_nettype none
module vio_link_end_a #(
  parameter int unsigned WIDTH = vio_link_pkg::WORD_W,
  parameter longint unsigned TIMEOUT_CYCLES = vio_link_pkg::MAX_TRANSFER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic out_valid,
  input wire logic [WIDTH-1:0] out_word,
  input wire logic module_fault,
  output logic [WIDTH-1:0] in_word,
  output logic link_up,
  output logic tx_busy,
  vio_link_if.end_a link
);
  vio_link_core #(.WIDTH(WIDTH), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_core (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .out_valid(out_valid),
    .out_word(out_word),
    .module_fault(module_fault),
    .in_word(in_word),
    .link_up(link_up),
    .tx_busy(tx_busy),
    .tx_line(link.a_to_b),
    .rx_line(link.b_to_a)
  );
endmodule

// one end of the cable: serialiser, deserialiser and link watchdog
module vio_link_core #(
  parameter int unsigned WIDTH = vio_link_pkg::WORD_W,
  parameter longint unsigned TIMEOUT_CYCLES = vio_link_pkg::MAX_TRANSFER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic out_valid,
  input wire logic [WIDTH-1:0] out_word,
  input wire logic module_fault,
  output logic [WIDTH-1:0] in_word,
  output logic link_up,
  output logic tx_busy,
  output logic tx_line,
  input wire logic rx_line
);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned BIT_W = $clog2(vio_link_pkg::FRAME_BITS);

  // frame must fit well inside the timeout, otherwise the link drops between frames;
  // the watchdog counter is 32 bits, so longer timeouts are refused
  if (WIDTH != vio_link_pkg::WORD_W || TIMEOUT_CYCLES < 4 * vio_link_pkg::FRAME_BITS ||
      TIMEOUT_CYCLES >= 64'h0000_0000_FFFF_FFFF) begin : g_bad_param
    $error("word width or timeout out of range");
  end

  vio_link_pkg::tx_state_e tx_state_q, tx_state_d;
  logic [WIDTH-1:0] tx_shift_q, tx_shift_d;
  logic [WIDTH-1:0] tx_pend_q, tx_pend_d;
  logic tx_pend_v_q, tx_pend_v_d;
  logic [BIT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic tx_par_q, tx_par_d;
  logic tx_line_q, tx_line_d;
  logic busy_q, busy_d;

  // transmit: a word from the base unit starts a frame at once, a word arriving
  // mid-frame is kept so the newest one follows right after
  always_comb begin
    tx_state_d = tx_state_q;
    tx_shift_d = tx_shift_q;
    tx_pend_d = tx_pend_q;
    tx_pend_v_d = tx_pend_v_q;
    tx_cnt_d = tx_cnt_q;
    tx_par_d = tx_par_q;
    tx_line_d = 1'b0;
    if (out_valid) begin
      tx_pend_d = module_fault ? '0 : out_word;
      tx_pend_v_d = 1'b1;
    end
    case (tx_state_q)
      vio_link_pkg::TX_IDLE: begin
        if (tx_pend_v_q || out_valid) begin
          tx_shift_d = tx_pend_d;
          tx_par_d = 1'b0;
          tx_pend_v_d = 1'b0;
          tx_cnt_d = '0;
          tx_line_d = 1'b1; // start bit
          tx_state_d = vio_link_pkg::TX_SHIFT;
        end
      end
      vio_link_pkg::TX_SHIFT: begin
        if (tx_cnt_q < BIT_W'(WIDTH)) begin
          tx_line_d = tx_shift_q[0]; // lsb first
          tx_par_d = tx_par_q ^ tx_shift_q[0];
          tx_shift_d = tx_shift_q >> 1;
          tx_cnt_d = tx_cnt_q + 1'b1;
        end else begin
          tx_line_d = tx_par_q;
          tx_state_d = vio_link_pkg::TX_GAP;
        end
      end
      vio_link_pkg::TX_GAP: begin
        tx_state_d = vio_link_pkg::TX_IDLE; // one idle low bit between frames
      end
      default: tx_state_d = vio_link_pkg::TX_IDLE;
    endcase
    busy_d = (tx_state_d != vio_link_pkg::TX_IDLE) || tx_pend_v_d; // a flop, so the base unit sees a clean level
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_state_q <= vio_link_pkg::TX_IDLE;
      tx_shift_q <= '0;
      tx_pend_q <= '0;
      tx_pend_v_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_shift_q <= tx_shift_d;
      tx_pend_q <= tx_pend_d;
      tx_pend_v_q <= tx_pend_v_d;
      tx_cnt_q <= tx_cnt_d;
      tx_par_q <= tx_par_d;
      tx_line_q <= tx_line_d;
      busy_q <= busy_d;
    end
  end

  vio_link_pkg::rx_state_e rx_state_q, rx_state_d;
  logic [WIDTH-1:0] rx_shift_q, rx_shift_d;
  logic [BIT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic rx_par_q, rx_par_d;
  logic [WIDTH-1:0] in_word_q, in_word_d;
  logic link_up_q, link_up_d;
  logic [CNT_W-1:0] wd_q, wd_d;

  // receive: frames with good parity refresh the input word; a watchdog
  // drops the link and zeros the word when none arrives in time
  always_comb begin
    rx_state_d = rx_state_q;
    rx_shift_d = rx_shift_q;
    rx_cnt_d = rx_cnt_q;
    rx_par_d = rx_par_q;
    in_word_d = in_word_q;
    link_up_d = link_up_q;
    wd_d = (wd_q < CNT_W'(TIMEOUT_CYCLES)) ? wd_q + 1'b1 : wd_q;
    case (rx_state_q)
      vio_link_pkg::RX_HUNT: begin
        if (rx_line) begin
          rx_cnt_d = '0;
          rx_par_d = 1'b0;
          rx_state_d = vio_link_pkg::RX_SHIFT;
        end
      end
      vio_link_pkg::RX_SHIFT: begin
        if (rx_cnt_q < BIT_W'(WIDTH)) begin
          rx_shift_d = {rx_line, rx_shift_q[WIDTH-1:1]};
          rx_par_d = rx_par_q ^ rx_line;
          rx_cnt_d = rx_cnt_q + 1'b1;
        end else begin
          rx_state_d = vio_link_pkg::RX_HUNT;
          if (rx_par_q == rx_line) begin
            in_word_d = rx_shift_q; // newest word held for the base unit
            link_up_d = 1'b1;
            wd_d = '0;
          end
        end
      end
      default: rx_state_d = vio_link_pkg::RX_HUNT;
    endcase
    // a fresh word in the same cycle as the timeout keeps the link up
    if (wd_q >= CNT_W'(TIMEOUT_CYCLES) && wd_d != '0) begin
      link_up_d = 1'b0;
      in_word_d = vio_link_pkg::INPUT_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_state_q <= vio_link_pkg::RX_HUNT;
      rx_shift_q <= '0;
      rx_cnt_q <= '0;
      rx_par_q <= 1'b0;
      in_word_q <= vio_link_pkg::INPUT_RESET;
      link_up_q <= 1'b0;
      wd_q <= '0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_shift_q <= rx_shift_d;
      rx_cnt_q <= rx_cnt_d;
      rx_par_q <= rx_par_d;
      in_word_q <= in_word_d;
      link_up_q <= link_up_d;
      wd_q <= wd_d;
    end
  end

  assign in_word = in_word_q;
  assign link_up = link_up_q;
  assign tx_line = tx_line_q;
  assign tx_busy = busy_q;
endmodule
`default_nettype wire

// [hw/vio_link_end_b.sv]
`timescale 1ns/100ps
`default_nettype none
// far end of the cable: same core, crossed lines
module vio_link_end_b #(
  parameter int unsigned WIDTH = vio_link_pkg::WORD_W,
  parameter longint unsigned TIMEOUT_CYCLES = vio_link_pkg::MAX_TRANSFER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic out_valid,
  input wire logic [WIDTH-1:0] out_word,
  input wire logic module_fault,
  output logic [WIDTH-1:0] in_word,
  output logic link_up,
  output logic tx_busy,
  vio_link_if.end_b link
);
  vio_link_core #(.WIDTH(WIDTH), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_core (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .out_valid(out_valid),
    .out_word(out_word),
    .module_fault(module_fault),
    .in_word(in_word),
    .link_up(link_up),
    .tx_busy(tx_busy),
    .tx_line(link.b_to_a),
    .rx_line(link.a_to_b)
  );
endmodule
`default_nettype wire

// [verif/vio_link_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// watches both cable lines; frame position is rebuilt from the start bit
module vio_link_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic a_to_b,
  input wire logic b_to_a,
  input wire logic ov_a,
  input wire logic ov_b,
  input wire logic bz_a,
  input wire logic bz_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [1:0] ln;
  logic [5:0] pos_q [2];
  logic [1:0] par_q;
  assign ln = {b_to_a, a_to_b};
  // pos 1..32 data, 33 parity, 34 gap; a start seen mid-frame is ignored
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst) begin
        pos_q[i] <= 6'h00;
        par_q[i] <= 1'b0;
      end else if (pos_q[i] == 6'h00) begin
        pos_q[i] <= {5'h00, ln[i]};
        par_q[i] <= 1'b0;
      end else begin
        pos_q[i] <= (pos_q[i] == 6'h22) ? 6'h00 : pos_q[i] + 6'h01;
        par_q[i] <= (pos_q[i] < 6'h21) ? (par_q[i] ^ ln[i]) : par_q[i];
      end
    end
  end
  property p_par_a;
    pos_q[0] == 6'h21 |-> a_to_b == par_q[0];
  endproperty
  a_par_a: assert property (p_par_a) else $error("parity wrong on a_to_b");
  property p_par_b;
    pos_q[1] == 6'h21 |-> b_to_a == par_q[1];
  endproperty
  a_par_b: assert property (p_par_b) else $error("parity wrong on b_to_a");
  property p_gap_a;
    pos_q[0] == 6'h22 |-> !a_to_b;
  endproperty
  a_gap_a: assert property (p_gap_a) else $error("no gap after frame on a_to_b");
  property p_gap_b;
    pos_q[1] == 6'h22 |-> !b_to_a;
  endproperty
  a_gap_b: assert property (p_gap_b) else $error("no gap after frame on b_to_a");
  property p_start_a;
    ov_a && !bz_a |=> a_to_b;
  endproperty
  a_start_a: assert property (p_start_a) else $error("start not tracked on a_to_b");
  property p_start_b;
    ov_b && !bz_b |=> b_to_a;
  endproperty
  a_start_b: assert property (p_start_b) else $error("start not tracked on b_to_a");
  property p_rst_a;
    $fell(sys_rst) |-> !a_to_b ##1 !a_to_b;
  endproperty
  a_rst_a: assert property (p_rst_a) else $error("a_to_b not low after reset");
  property p_rst_b;
    $fell(sys_rst) |-> !b_to_a ##1 !b_to_a;
  endproperty
  a_rst_b: assert property (p_rst_b) else $error("b_to_a not low after reset");
  c_frame_a: cover property (pos_q[0] == 6'h21);
  c_frame_b: cover property (pos_q[1] == 6'h21);
  c_release: cover property ($fell(sys_rst));
endmodule
`default_nettype wire

// [verif/tb_virtual_io_link_exchange.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_virtual_io_link_exchange;
  logic clk_sys, sys_rst, ov_a, ov_b, flt_a, flt_b, up_a, up_b, bz_a, bz_b;
  logic [31:0] ow_a, ow_b, iw_a, iw_b;
  int failures = 0;
  int n_tests = 0;
  // columns: word from a, word from b, expected at b, expected at a
  logic [31:0] rows [4][4] = '{
    '{32'h0000_0001, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000},
    '{32'h0000_0020, 32'hFFFF_FFFF, 32'h0000_0020, 32'hFFFF_FFFF},
    '{32'hA5A5_5A5A, 32'h0000_0000, 32'hA5A5_5A5A, 32'h0000_0000},
    '{32'h7FFF_FFFE, 32'h1357_9BDF, 32'h7FFF_FFFE, 32'h1357_9BDF}};
  vio_link_if vio_link_if_inst (); // exactly two link ends share this cable
  // one link module per base unit here, well under the allowed count
  localparam int unsigned LINKS_ON_UNIT = 1;
  if (LINKS_ON_UNIT > vio_link_pkg::MAX_LINKS_PER_UNIT) begin : g_too_many_links
    $error("too many link modules on one base unit");
  end
  // small timeout keeps the loss test short
  vio_link_end_a #(.TIMEOUT_CYCLES(200)) vio_link_end_a_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .out_valid(ov_a), .out_word(ow_a), .module_fault(flt_a), .in_word(iw_a), .link_up(up_a),
    .tx_busy(bz_a), .link(vio_link_if_inst.end_a));
  vio_link_end_b #(.TIMEOUT_CYCLES(200)) vio_link_end_b_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .out_valid(ov_b), .out_word(ow_b), .module_fault(flt_b), .in_word(iw_b), .link_up(up_b),
    .tx_busy(bz_b), .link(vio_link_if_inst.end_b));
  vio_link_asserts vio_link_asserts_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .a_to_b(vio_link_if_inst.a_to_b), .b_to_a(vio_link_if_inst.b_to_a),
    .ov_a(ov_a), .ov_b(ov_b), .bz_a(bz_a), .bz_b(bz_b));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // both ends send at once, then wait (bounded) until both lines are idle
  task automatic xfer(input logic [31:0] wa, input logic [31:0] wb);
    int n;
    n = 0;
    ow_a = wa;
    ow_b = wb;
    ov_a = 1'b1;
    ov_b = 1'b1;
    @(negedge clk_sys);
    ov_a = 1'b0;
    ov_b = 1'b0;
    check("busy_a", {31'h0, bz_a}, 32'h0000_0001);
    check("busy_b", {31'h0, bz_b}, 32'h0000_0001);
    while ((bz_a !== 1'b0 || bz_b !== 1'b0) && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check("xfer_time", {31'h0, n < 100}, 32'h0000_0001);
    repeat (3) @(negedge clk_sys);
  endtask
  initial begin
    sys_rst = 1'b1;
    {ov_a, ov_b, flt_a, flt_b} = 4'h0;
    ow_a = 32'h0000_0000;
    ow_b = 32'h0000_0000;
    repeat (8) @(negedge clk_sys);
    check("rst_in_a", iw_a, 32'h0000_0000);
    check("rst_up_b", {31'h0, up_b}, 32'h0000_0000);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      xfer(rows[i][0], rows[i][1]);
      check("in_b", iw_b, rows[i][2]);
      check("in_a", iw_a, rows[i][3]);
      check("up_b", {31'h0, up_b}, 32'h0000_0001);
      check("up_a", {31'h0, up_a}, 32'h0000_0001);
    end
    // second word right behind the first must replace it
    ow_a = 32'h1234_5678;
    ov_a = 1'b1;
    @(negedge clk_sys);
    xfer(32'h0BAD_F00D, 32'h0000_0000);
    check("b2b_b", iw_b, 32'h0BAD_F00D);
    // faulty end sends zeros while the peer keeps running
    flt_a = 1'b1;
    xfer(32'hFFFF_FFFF, 32'h0000_0020);
    check("flt_b", iw_b, 32'h0000_0000);
    check("flt_a", iw_a, 32'h0000_0020);
    flt_a = 1'b0;
    // silence past the timeout drops the link
    repeat (260) @(negedge clk_sys);
    check("lost_up_b", {31'h0, up_b}, 32'h0000_0000);
    check("lost_in_a", iw_a, 32'h0000_0000);
    check("lost_up_a", {31'h0, up_a}, 32'h0000_0000);
    check("lost_in_b", iw_b, 32'h0000_0000);
    // reset in mid-frame: both ends must come back idle and link again
    ow_a = 32'h5555_AAAA;
    ov_a = 1'b1;
    @(negedge clk_sys);
    ov_a = 1'b0;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("mid_rst_busy_a", {31'h0, bz_a}, 32'h0000_0000);
    check("mid_rst_up_b", {31'h0, up_b}, 32'h0000_0000);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    xfer(rows[3][0], rows[3][1]);
    check("mid_rst_in_b", iw_b, rows[3][2]);
    check("mid_rst_in_a", iw_a, rows[3][3]);
    wrap_up();
  end
  initial begin
    #(25 * 5000);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
